//--- hw/t3p_timer.sv
// Purpose: 8-bit timer/counter with compare, capture and 10-bit PWM output
// Assumes: Plain register port, one clock, neighbour timer on the same clock
// Notes:   Read data stand in the cycle after the read strobe only
//
// How it works
// R1: Control register, reset zero: polarity, cascade, PWM, capture, clock select, continue, start.
// R2: Write-only compare value, reset all ones; counter match makes the compare event.
// R3: In PWM mode, compare address writes load the period low byte, reset all ones.
// R4: With PWM and capture off, counter address reads return the live count, reset zero.
// R5: Duty low byte, reset zero, written only with PWM enabled; other writes ignored.
// R6: In capture mode the counter address reads the captured count, reset zero.
// R7: High register bit 7 gates the waveform onto the output pin, reset zero.
// R8: The whole high register is write-only and reads back as zero.
// R9: High bits 3:2 extend the period to ten bits.
// R10: High bits 1:0 extend the duty to ten bits.
// R11: Duty equal to period gives the polarity level; zero duty gives the inverse.
// R12: Compare mode toggles the output on every match, a square wave.
// R13: Polarity sets or clears the output on duty match; period end restores.
// R14: Start clears the count, start with continue runs, clear continue pauses, source three uses the enabled neighbour clock.
//
// Local design decision: the plain strobed port.

`timescale 1ns/1ps

module t3p_timer
  import t3p_pkg::*;
(
  // Clock and reset
  input  logic              i_mclk,
  input  logic              i_sys_rst,
  // Register port
  input  logic [7:0]        i_addr,
  input  logic [7:0]        i_wdata,
  input  logic              i_wr,
  input  logic              i_rd,
  output logic [7:0]        o_rdata,
  // Neighbour timer
  input  logic              i_neighbour_tick,
  input  logic              i_neighbour_timer_enable,
  input  logic              i_neighbour_carry,
  input  logic              i_neighbour_match,
  // Capture pin
  input  logic              i_capture_pin,
  // Waveform pin
  output logic              o_waveform_output_pin,
  output logic              o_output_pin_enable
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] cmp;
    logic [7:0] per_lo;
    logic [7:0] duty_lo;
    logic [4:0] high;
    logic [9:0] cnt;
    logic [7:0] cap;
    logic       toggle;
    logic       wave;
    logic       pin_en;
    logic [7:0] rdata;
    logic       sync1;
    logic       sync2;
    logic       sync3;
    logic       cap_lvl;
  } t3p_state_t;

  t3p_state_t st_reg;
  t3p_state_t st_next;

  t3p_core_if core_if ();

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // PWM wins over capture when both are set
  function automatic t3p_mode_t mode_of(input logic [7:0] ctrl);
    if (ctrl[CTRL_PWM_EN]) begin
      return MODE_PWM;
    end else if (ctrl[CTRL_CAP]) begin
      return MODE_CAPTURE;
    end else begin
      return MODE_TIMER;
    end
  endfunction

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] reg_addr);
    return (addr == reg_addr);
  endfunction

  // ---------------------------------------------------------------------------
  // Helper instances
  // ---------------------------------------------------------------------------
  t3p_prescaler u_presc (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .core      (core_if.presc)
  );

  t3p_pwm_gen u_pwm (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .core      (core_if.pwm)
  );

  assign core_if.clk_sel = st_reg.ctrl[CTRL_CLK_HI:CTRL_CLK_LO];
  assign core_if.count   = st_reg.cnt;
  assign core_if.period  = {st_reg.high[HIGH_PER_HI:HIGH_PER_LO], st_reg.per_lo};    // R9
  assign core_if.duty    = {st_reg.high[HIGH_DUTY_HI:HIGH_DUTY_LO], st_reg.duty_lo}; // R10
  assign core_if.pwm_polarity     = st_reg.ctrl[CTRL_POL];

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  t3p_mode_t  mode;
  logic       run;
  logic       cascade;
  logic       src_tick;
  logic       step;
  logic       match;
  logic       period_end;
  logic       cap_event;
  logic       wr_ctrl;
  logic       wr_cmp;
  logic       wr_cnt;
  logic       wr_high;
  logic [9:0] period;

  always_comb begin
    st_next = st_reg;

    mode    = mode_of(st_reg.ctrl);
    cascade = st_reg.ctrl[CTRL_CASCADE];
    run     = st_reg.ctrl[CTRL_START] & st_reg.ctrl[CTRL_CONT];             // R14
    period  = core_if.period;

    wr_ctrl = i_wr & hit(i_addr, ADDR_CTRL);
    wr_cmp  = i_wr & hit(i_addr, ADDR_CMP);
    wr_cnt  = i_wr & hit(i_addr, ADDR_CNT);
    wr_high = i_wr & hit(i_addr, ADDR_HIGH);

    // Neighbour clock only counts while that timer is enabled
    if (core_if.clk_sel == CLK_NEIGHBOUR) begin
      src_tick = i_neighbour_tick & i_neighbour_timer_enable;               // R14
    end else begin
      src_tick = core_if.tick;
    end

    // Outside PWM mode a cascaded pair steps on the low timer's carry and matches jointly
    if (cascade && mode != MODE_PWM) begin
      step  = run & i_neighbour_carry;
      match = (st_reg.cnt[7:0] == st_reg.cmp) & i_neighbour_match;          // R12
    end else begin
      step  = run & src_tick;
      match = (st_reg.cnt[7:0] == st_reg.cmp);                              // R2
    end
    period_end = (st_reg.cnt == period);

    // Capture pin: three flops, a rising edge counts once stages two and three agree
    st_next.sync1 = i_capture_pin;
    st_next.sync2 = st_reg.sync1;
    st_next.sync3 = st_reg.sync2;
    cap_event     = 1'b0;
    if (st_reg.sync2 == st_reg.sync3) begin
      st_next.cap_lvl = st_reg.sync3;
      cap_event       = st_reg.sync3 & ~st_reg.cap_lvl;
    end

    // ---------------------------------------------------------------------------
    // Counter
    // ---------------------------------------------------------------------------
    if (step) begin
      unique case (mode)
        MODE_PWM: begin
          if (period_end) begin
            st_next.cnt = RST_CNT;                                          // R13
          end else begin
            st_next.cnt = st_reg.cnt + 10'h001;
          end
        end
        MODE_CAPTURE, MODE_TIMER: begin
          if (match) begin
            st_next.cnt    = RST_CNT;
            st_next.toggle = ~st_reg.toggle;                                // R12
          end else begin
            st_next.cnt = {2'b00, st_reg.cnt[7:0] + 8'h01};
          end
        end
      endcase
    end

    // Capture keeps running while the counter is paused, so software can
    // still timestamp an edge against a held count
    if (cap_event && mode == MODE_CAPTURE) begin
      st_next.cap = st_reg.cnt[7:0];                                        // R6
    end

    // ---------------------------------------------------------------------------
    // Register writes
    // ---------------------------------------------------------------------------
    if (wr_ctrl) begin
      st_next.ctrl = i_wdata;                                               // R1
      if (i_wdata[CTRL_START]) begin
        st_next.cnt = RST_CNT;                                              // R14
      end
    end

    if (wr_cmp) begin
      if (mode == MODE_PWM) begin
        st_next.per_lo = i_wdata;                                           // R3
      end else begin
        st_next.cmp = i_wdata;                                              // R2
      end
    end

    // Duty writes outside PWM mode are dropped
    if (wr_cnt && mode == MODE_PWM) begin
      st_next.duty_lo = i_wdata;                                            // R5
    end

    if (wr_high) begin
      st_next.high = {i_wdata[HIGH_OE], i_wdata[HIGH_PER_HI:HIGH_DUTY_LO]}; // R7
    end

    // ---------------------------------------------------------------------------
    // Waveform pin
    // ---------------------------------------------------------------------------
    st_next.pin_en = st_reg.high[4];                                        // R7
    if (!st_reg.high[4]) begin
      st_next.wave = 1'b0;                                                  // R7
    end else if (mode == MODE_PWM) begin
      st_next.wave = core_if.pwm_level;                                     // R11
    end else begin
      st_next.wave = st_reg.toggle;                                         // R12
    end

    // ---------------------------------------------------------------------------
    // Register reads: data stand one cycle, zero otherwise
    // ---------------------------------------------------------------------------
    st_next.rdata = RST_RDATA;
    if (i_rd) begin
      if (hit(i_addr, ADDR_CTRL)) begin
        st_next.rdata = st_reg.ctrl;                                        // R1
      end else if (hit(i_addr, ADDR_CNT)) begin
        unique case (mode)
          MODE_PWM:     st_next.rdata = st_reg.duty_lo;                     // R5
          MODE_CAPTURE: st_next.rdata = st_reg.cap;                         // R6
          MODE_TIMER:   st_next.rdata = st_reg.cnt[7:0];                    // R4
        endcase
      end else begin
        // Compare, period and high register are write-only
        st_next.rdata = RST_RDATA;                                          // R8
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_reg.ctrl    <= RST_CTRL;
      st_reg.cmp     <= RST_CMP;
      st_reg.per_lo  <= RST_PER;
      st_reg.duty_lo <= RST_DUTY;
      st_reg.high    <= RST_HIGH;
      st_reg.cnt     <= RST_CNT;
      st_reg.cap     <= RST_CAP;
      st_reg.toggle  <= 1'b0;
      st_reg.wave    <= 1'b0;
      st_reg.pin_en  <= 1'b0;
      st_reg.rdata   <= RST_RDATA;
      st_reg.sync1   <= 1'b0;
      st_reg.sync2   <= 1'b0;
      st_reg.sync3   <= 1'b0;
      st_reg.cap_lvl <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign o_rdata               = st_reg.rdata;
  assign o_waveform_output_pin = st_reg.wave;
  assign o_output_pin_enable   = st_reg.pin_en;

endmodule

//--- shared/t3p_pkg.sv
// Purpose: Constants and types shared by the timer/PWM unit and its helpers
// Assumes: 8-bit register bus, one 100 MHz clock
// Notes:   Register offsets are the byte addresses on the plain register port

package t3p_pkg;

  // ---------------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'hCA;
  localparam logic [7:0] ADDR_CMP  = 8'hCB;
  localparam logic [7:0] ADDR_CNT  = 8'hCC;
  localparam logic [7:0] ADDR_HIGH = 8'hCD;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int CTRL_POL     = 7;
  localparam int CTRL_CASCADE = 6;
  localparam int CTRL_PWM_EN  = 5;
  localparam int CTRL_CAP     = 4;
  localparam int CTRL_CLK_HI  = 3;
  localparam int CTRL_CLK_LO  = 2;
  localparam int CTRL_CONT    = 1;
  localparam int CTRL_START   = 0;
  localparam int HIGH_OE      = 7;
  localparam int HIGH_PER_HI  = 3;
  localparam int HIGH_PER_LO  = 2;
  localparam int HIGH_DUTY_HI = 1;
  localparam int HIGH_DUTY_LO = 0;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] RST_CTRL  = 8'h00;
  localparam logic [7:0] RST_CMP   = 8'hFF;
  localparam logic [7:0] RST_PER   = 8'hFF;
  localparam logic [7:0] RST_DUTY  = 8'h00;
  localparam logic [7:0] RST_CAP   = 8'h00;
  localparam logic [9:0] RST_CNT   = 10'h000;
  localparam logic [4:0] RST_HIGH  = 5'h00;
  localparam logic [7:0] RST_RDATA = 8'h00;

  // ---------------------------------------------------------------------------
  // Clock source codes and prescaler masks
  // ---------------------------------------------------------------------------
  localparam logic [1:0] CLK_FX        = 2'h0;
  localparam logic [1:0] CLK_DIV_A     = 2'h1;
  localparam logic [1:0] CLK_DIV_B     = 2'h2;
  localparam logic [1:0] CLK_NEIGHBOUR = 2'h3;
  localparam logic [7:0] PRESC_MASK_A  = 8'h03;
  localparam logic [7:0] PRESC_MASK_B  = 8'h0F;

  typedef enum logic [2:0] {
    MODE_TIMER   = 3'b001,
    MODE_CAPTURE = 3'b010,
    MODE_PWM     = 3'b100
  } t3p_mode_t;

endpackage

//--- shared/t3p_core_if.sv
// Purpose: Carries clock-source and PWM signals between the timer core and helpers
// Assumes: All signals live on the one system clock
// Notes:   No clocking; plain nets with three views

`timescale 1ns/1ps

interface t3p_core_if;
  logic [1:0] clk_sel;
  logic       tick;
  logic [9:0] count;
  logic [9:0] duty;
  logic [9:0] period;
  logic       pwm_polarity;
  logic       pwm_level;

  modport core  (output clk_sel, count, duty, period, pwm_polarity, input tick, pwm_level);
  modport presc (input clk_sel, output tick);
  modport pwm   (input count, duty, period, pwm_polarity, output pwm_level);
endinterface

//--- hw/t3p_prescaler.sv
// Purpose: Divides the system clock into a one-cycle count tick
// Assumes: Select code comes from the timer core
// Notes:   Neighbour source gives no tick here; the core supplies it

`timescale 1ns/1ps

module t3p_prescaler
  import t3p_pkg::*;
(
  // Clock and reset
  input  logic              i_mclk,
  input  logic              i_sys_rst,
  // Core link
  t3p_core_if.presc         core
);

  typedef struct packed {
    logic [7:0] div;
    logic       tick;
  } t3p_presc_state_t;

  t3p_presc_state_t st_reg;
  t3p_presc_state_t st_next;

  always_comb begin
    st_next     = st_reg;
    st_next.div = st_reg.div + 8'h01;
    unique case (core.clk_sel)
      CLK_FX:        st_next.tick = 1'b1;
      CLK_DIV_A:     st_next.tick = ((st_reg.div & PRESC_MASK_A) == PRESC_MASK_A);
      CLK_DIV_B:     st_next.tick = ((st_reg.div & PRESC_MASK_B) == PRESC_MASK_B);
      CLK_NEIGHBOUR: st_next.tick = 1'b0;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign core.tick = st_reg.tick;

endmodule

//--- hw/t3p_pwm_gen.sv
// Purpose: Works out the registered 10-bit PWM level from count, duty and period
// Assumes: Core wraps the count to zero after it reaches the period
// Notes:   Equal duty and period, and zero duty, give steady levels

`timescale 1ns/1ps

module t3p_pwm_gen
  import t3p_pkg::*;
(
  // Clock and reset
  input  logic              i_mclk,
  input  logic              i_sys_rst,
  // Core link
  t3p_core_if.pwm           core
);

  typedef struct packed {
    logic level;
  } t3p_pwm_state_t;

  t3p_pwm_state_t st_reg;
  t3p_pwm_state_t st_next;

  always_comb begin
    st_next = st_reg;
    if (core.duty == core.period) begin
      st_next.level = core.pwm_polarity;                                  // R11
    end else if (core.duty == 10'h000) begin
      st_next.level = ~core.pwm_polarity;                                 // R11
    end else if (core.count >= core.duty) begin
      // Past the duty match: set for positive, clear for negative
      st_next.level = core.pwm_polarity;                                  // R13
    end else begin
      st_next.level = ~core.pwm_polarity;                                 // R13
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign core.pwm_level = st_reg.level;

endmodule

//--- verification/t3p_timer_checker.sv
// Purpose: Port-level assertions for the timer/PWM unit
// Assumes: One clock, reset active high and asynchronous
// Notes:   PWM enable is shadowed from control writes seen at the port

`timescale 1ns/1ps

module t3p_timer_checker
  import t3p_pkg::*;
(
  // Clock and reset
  input logic       i_mclk,
  input logic       i_sys_rst,
  // Register port
  input logic [7:0] i_addr,
  input logic [7:0] i_wdata,
  input logic       i_wr,
  input logic       i_rd,
  input logic [7:0] o_rdata,
  // Waveform pin
  input logic       o_waveform_output_pin,
  input logic       o_output_pin_enable
);
  // ---------------------------------------------------------------------------
  // Helper logic
  // ---------------------------------------------------------------------------
  logic pwm_on_reg;
  logic hi_wr;
  logic oe_bit;

  assign hi_wr  = i_wr && i_addr == ADDR_HIGH;
  assign oe_bit = i_wdata[HIGH_OE];

  // Duty writes only count when the shadowed enable was already set
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pwm_on_reg <= 1'b0;
    end else if (i_wr && i_addr == ADDR_CTRL) begin
      pwm_on_reg <= i_wdata[CTRL_PWM_EN];
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  sequence s_wr(a); i_wr && i_addr == a; endsequence
  sequence s_rd(a); i_rd && i_addr == a; endsequence
  sequence s_duty_wr; i_wr && i_addr == ADDR_CNT && pwm_on_reg; endsequence
  sequence s_duty_rd; i_rd && i_addr == ADDR_CNT && pwm_on_reg; endsequence

  property p_rst_quiet;
    $fell(i_sys_rst) |-> o_rdata == RST_RDATA && !o_output_pin_enable && !o_waveform_output_pin;
  endproperty
  property p_rdata_idle;
    !$past(i_rd) |-> o_rdata == 8'h00;
  endproperty
  property p_ctrl_back;
    s_wr(ADDR_CTRL) ##2 s_rd(ADDR_CTRL) |=> o_rdata == $past(i_wdata, 3);
  endproperty
  property p_cmp_wo;
    s_rd(ADDR_CMP) |=> o_rdata == 8'h00;
  endproperty
  property p_high_wo;
    s_rd(ADDR_HIGH) |=> o_rdata == 8'h00;
  endproperty
  property p_duty_back;
    s_duty_wr ##2 s_duty_rd |=> o_rdata == $past(i_wdata, 3);
  endproperty
  property p_oe_follow;
    hi_wr |-> ##2 o_output_pin_enable == $past(oe_bit, 2);
  endproperty
  property p_oe_cause;
    $changed(o_output_pin_enable) |-> $past(hi_wr, 2);
  endproperty
  property p_pin_gate;
    !o_output_pin_enable |-> !o_waveform_output_pin;
  endproperty

  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs not quiet after reset");
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside read");
  a_ctrl_back: assert property (p_ctrl_back) else $error("control readback wrong");
  a_cmp_wo: assert property (p_cmp_wo) else $error("compare address read not zero");
  a_high_wo: assert property (p_high_wo) else $error("high register read not zero");
  a_duty_back: assert property (p_duty_back) else $error("duty readback wrong");
  a_oe_follow: assert property (p_oe_follow) else $error("pin enable not taken from write");
  a_oe_cause: assert property (p_oe_cause) else $error("pin enable moved without write");
  a_pin_gate: assert property (p_pin_gate) else $error("waveform driven while disabled");
endmodule

bind t3p_timer t3p_timer_checker u_t3p_timer_checker (
  .i_mclk                (i_mclk),
  .i_sys_rst             (i_sys_rst),
  .i_addr                (i_addr),
  .i_wdata               (i_wdata),
  .i_wr                  (i_wr),
  .i_rd                  (i_rd),
  .o_rdata               (o_rdata),
  .o_waveform_output_pin (o_waveform_output_pin),
  .o_output_pin_enable   (o_output_pin_enable)
);

//--- verification/t3p_timer_bench.sv
// Purpose: Self-checking bench for the timer/PWM unit
// Assumes: Cascade carry is the neighbour tick gated by its enable; neighbour tick toggles every cycle
// Notes:   Reads sample the data one cycle after the strobe

`timescale 1ns/1ps

module t3p_timer_bench
  import t3p_pkg::*;
();
  logic       i_mclk    = 1'b0;
  logic       i_sys_rst = 1'b1;
  logic [7:0] i_addr    = 8'h00;
  logic [7:0] i_wdata   = 8'h00;
  logic       i_wr      = 1'b0;
  logic       i_rd      = 1'b0;
  logic       nb_tick   = 1'b0;
  logic       nb_en     = 1'b0;
  logic       cap_pin   = 1'b0;
  logic [7:0] rdata;
  logic       wave;
  logic       pin_oe;
  int         n_errors   = 0;
  int         n_compared = 0;

  always #5 i_mclk = ~i_mclk;
  always @(posedge i_mclk) nb_tick <= ~nb_tick;

  t3p_timer u_t3p_timer (
    .i_mclk                   (i_mclk),
    .i_sys_rst                (i_sys_rst),
    .i_addr                   (i_addr),
    .i_wdata                  (i_wdata),
    .i_wr                     (i_wr),
    .i_rd                     (i_rd),
    .o_rdata                  (rdata),
    .i_neighbour_tick         (nb_tick),
    .i_neighbour_timer_enable (nb_en),
    .i_neighbour_carry        (nb_tick & nb_en),
    .i_neighbour_match        (nb_en),
    .i_capture_pin            (cap_pin),
    .o_waveform_output_pin    (wave),
    .o_output_pin_enable      (pin_oe)
  );

  // ---------------------------------------------------------------------------
  // Bus and check tasks
  // ---------------------------------------------------------------------------
  task automatic close_out();
    if (n_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(string what, logic [9:0] want, logic [9:0] got);
    n_compared++;
    if (got !== want) begin
      n_errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, want, got);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge i_mclk);
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge i_mclk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a, output logic [7:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Cycles until the pin next changes; a stuck pin ends the run
  task automatic gap(output int n);
    logic p;
    p = wave;
    n = 0;
    do begin
      @(posedge i_mclk);
      #1 n++;
    end while (wave === p && n < 40);
    if (n == 40) begin
      chk("edge timeout", 10'h000, 10'h001);
      close_out();
    end
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] adr [5] = '{ADDR_CTRL, ADDR_CMP, ADDR_CNT, ADDR_HIGH, 8'h10};
    logic [7:0] v;
    chk("oe", 10'h000, 10'(pin_oe));
    foreach (adr[i]) begin
      rd(adr[i], v);
      chk("reset read", 10'h000, 10'(v));
    end
  endtask

  task automatic t_ctrl();
    logic [7:0] pat [4] = '{8'hA5, 8'h5A, 8'hFF, 8'h00};
    logic [7:0] v;
    foreach (pat[i]) begin
      wr(ADDR_CTRL, pat[i]);
      rd(ADDR_CTRL, v);
      chk("ctrl", 10'(pat[i]), 10'(v));
    end
    wr(8'h10, 8'h77);
    rd(ADDR_CTRL, v);
    chk("ctrl after unmapped", 10'h000, 10'(v));
    wr(ADDR_HIGH, 8'h0F);
    rd(ADDR_HIGH, v);
    chk("high readback", 10'h000, 10'(v));
  endtask

  // Two reads 64 cycles apart, a multiple of every prescaler ratio
  task automatic t_rates();
    logic [7:0] ctl [7] = '{8'h03, 8'h07, 8'h0B, 8'h0F, 8'h0F, 8'h01, 8'h43};
    logic [7:0] stp [7] = '{8'h40, 8'h10, 8'h04, 8'h00, 8'h20, 8'h00, 8'h20};
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] d;
    wr(ADDR_CMP, 8'hFF);
    foreach (ctl[i]) begin
      wr(ADDR_CTRL, ctl[i]);
      nb_en <= (i == 4 || i == 6);
      cyc(4);
      rd(ADDR_CNT, a);
      cyc(62);
      rd(ADDR_CNT, b);
      d = b - a;
      chk("count step", 10'(stp[i]), 10'(d));
    end
  endtask

  task automatic t_capture();
    logic [7:0] a;
    logic [7:0] b;
    wr(ADDR_CTRL, 8'h13);
    rd(ADDR_CNT, a);
    chk("capture reset", 10'h000, 10'(a));
    cyc(20);
    cap_pin <= 1'b1;
    cyc(10);
    rd(ADDR_CNT, a);
    cyc(7);
    cap_pin <= 1'b0;
    rd(ADDR_CNT, b);
    chk("capture held", 10'(a), 10'(b));
    chk("capture window", 10'h001, 10'(a >= 8'h14 && a <= 8'h28));
  endtask

  task automatic t_wave();
    int n;
    wr(ADDR_CTRL, 8'h03);
    wr(ADDR_CMP, 8'h05);
    wr(ADDR_HIGH, 8'h80);
    cyc(3);
    #1;
    chk("oe on", 10'h001, 10'(pin_oe));
    gap(n);
    gap(n);
    chk("half period", 10'h006, 10'(n));
    gap(n);
    chk("half period", 10'h006, 10'(n));
    // Cascade: the pair steps on every neighbour carry, here every other cycle
    wr(ADDR_CTRL, 8'h43);
    nb_en <= 1'b1;
    gap(n);
    gap(n);
    gap(n);
    chk("cascade half period", 10'h00C, 10'(n));
    wr(ADDR_HIGH, 8'h00);
    cyc(3);
    chk("oe off", 10'h000, 10'(pin_oe));
    chk("pin off", 10'h000, 10'(wave));
  endtask

  // Period 10 cycles, or 266 with the high period bit set
  task automatic t_pwm();
    logic [7:0] ctl [8] = '{8'h23, 8'hA3, 8'h23, 8'hA3, 8'h23, 8'hA3, 8'h23, 8'h23};
    logic [7:0] dut [8] = '{8'h02, 8'h02, 8'h00, 8'h00, 8'h09, 8'h09, 8'h02, 8'h02};
    logic [7:0] hi  [8] = '{8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h84, 8'h85};
    int         win [8] = '{100, 100, 100, 100, 100, 100, 266, 266};
    int         hit [8] = '{20, 80, 100, 0, 0, 100, 2, 258};
    logic [7:0] v;
    int         n;
    wr(ADDR_CNT, 8'h33);
    wr(ADDR_CTRL, 8'h23);
    rd(ADDR_CNT, v);
    chk("duty refused", 10'h000, 10'(v));
    wr(ADDR_CMP, 8'h09);
    foreach (ctl[i]) begin
      wr(ADDR_CTRL, ctl[i]);
      wr(ADDR_HIGH, hi[i]);
      wr(ADDR_CNT, dut[i]);
      rd(ADDR_CNT, v);
      chk("duty low", 10'(dut[i]), 10'(v));
      cyc(300);
      n = 0;
      repeat (win[i]) begin
        @(posedge i_mclk);
        #1 n += int'(wave === 1'b1);
      end
      chk("high cycles", 10'(hit[i]), 10'(n));
    end
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    t_reset();
    t_ctrl();
    t_rates();
    t_capture();
    t_wave();
    t_pwm();
    close_out();
  end
endmodule
